// *** logic/spc_pkg.sv ***
// Package for the serial programming command handler.
// Assumes a byte-wide receive stream with valid only and a transmit stream with valid and ready.
package spc_pkg;

  // Delay counts in core clock cycles
  localparam int unsigned SYNC_ECHO_DELAY = 660;
  localparam int unsigned BAUD_ECHO_DELAY = 540;
  localparam int unsigned CMD_ECHO_DELAY = 300;
  localparam int unsigned FLASH_SUM_DELAY = 746670;
  localparam int unsigned RAM_SUM_DELAY = 160;
  localparam int unsigned WRITE_RESP_DELAY = 200;
  localparam int unsigned READ_START_DELAY = 430;
  localparam int unsigned EMU_ECHO_DELAY = 420;
  localparam int unsigned PROTECT_DELAY = 1080;
  localparam int CNT_W = 20;

  // Sync and command codes
  localparam logic [7:0] SYNC_BYTE = 8'h86;
  localparam logic [7:0] BAUD_BYTE = 8'h79;
  localparam logic [7:0] OP_READ = 8'h40;
  localparam logic [7:0] OP_SUM = 8'h90;
  localparam logic [7:0] OP_ID = 8'hC0;
  localparam logic [7:0] OP_STATUS = 8'hC3;
  localparam logic [7:0] OP_EMU = 8'hD0;
  localparam logic [7:0] OP_ERASE = 8'hF0;
  localparam logic [7:0] ERASE_FREE_CODE = 8'hFF;
  localparam logic [7:0] CHIP_ERASE_SEL = 8'h00;
  localparam logic [7:0] STATUS_PROT_BIT = 8'h01;
  localparam logic [7:0] STATUS_CLEAR = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // Handler states
  typedef enum logic [3:0] {
    SPC_WAIT_SYNC = 4'h0,
    SPC_WAIT_BAUD = 4'h1,
    SPC_IDLE_CMD = 4'h2,
    SPC_DELAY = 4'h3,
    SPC_SEND = 4'h4,
    SPC_WAIT_ARG = 4'h5,
    SPC_READ_OUT = 4'h6,
    SPC_HALT = 4'h7
  } spc_state_e;

  // Byte carried on a stream
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spc_byte_s;

endpackage : spc_pkg

// *** logic/spc_handler.sv ***
// Serial programming command handler with output FIFO.
// Assumes a UART outside delivers received bytes and drains transmit bytes.
`timescale 1ns/10ps

// Output byte FIFO
module spc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  // Flags from pointer difference
  always_comb begin
    in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    out_valid = wr_ptr != rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
    do_wr = in_valid && in_ready;
    do_rd = out_valid && out_ready;
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
  end

  // Pointer registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : spc_fifo

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// - Echo sync byte 0x86 about 660 cycles after receipt.
// - Echo baud byte 0x79 about 540 cycles after receipt.
// - Echo operation command about 300 cycles after receipt.
// - Flash checksum takes about 746670 cycles over 16KB.
// - RAM checksum takes about 160 cycles.
// - Overwrite-detection reply about 200 cycles after write block.
// - Memory data starts about 430 cycles after byte count.
// - Emulation data byte echoed about 420 cycles later.
// - Enabling read protection takes about 1080 cycles.
// - Code 0x40 reads flash and returns requested bytes.
// - Code 0x90 waits the flash checksum time, then sends 0x00.
// - Code 0xC0 sends product identification.
// - Code 0xC3 sends flash status with protection state.
// - Code 0xD0 sets up emulation, then takes one data byte.
// - Code 0xF0 erases only when option byte is 0xFF; there is no password path.
// - Sector erase with password-free option set halts the device.
module spc_handler
  import spc_pkg::*;
#(
  parameter int unsigned FLASH_SUM_CYCLES = FLASH_SUM_DELAY,
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] PRODUCT_ID = 8'h5A // Arbitrary value
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Received byte stream
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // Transmit byte stream
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  // Device options and memory
  input wire logic [7:0] erase_password_free_option,
  input wire logic protect_req,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] mem_addr,
  // Status
  output logic busy,
  output logic halted,
  output logic protected_flag
);
  spc_state_e state;
  spc_state_e next_state;
  spc_state_e after_state;
  spc_state_e next_after_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [7:0] out_byte;
  logic [7:0] next_out_byte;
  logic [7:0] remain;
  logic [7:0] next_remain;
  logic [7:0] addr;
  logic [7:0] next_addr;
  logic prot;
  logic next_prot;
  logic reply_pend;
  logic next_reply_pend;
  logic [7:0] reply_byte;
  logic [7:0] next_reply_byte;
  logic [CNT_W-1:0] reply_cnt;
  logic [CNT_W-1:0] next_reply_cnt;
  logic busy_q;
  logic halt_q;
  spc_byte_s push;
  logic push_ready;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // Delay count to cycle counter width
  function automatic logic [CNT_W-1:0] dly(input int unsigned c);
    dly = CNT_W'(c - 1);
  endfunction : dly

  // Decoding of the operation code into its delay
  function automatic logic [CNT_W-1:0] op_delay(input logic [7:0] op);
    unique case (op)
      OP_SUM: op_delay = dly(FLASH_SUM_CYCLES);
      default: op_delay = dly(CMD_ECHO_DELAY);
    endcase
  endfunction : op_delay

  // Command sequencer next values
  always_comb begin
    next_state = state;
    next_after_state = after_state;
    next_cnt = cnt;
    next_cmd = cmd;
    next_out_byte = out_byte;
    next_remain = remain;
    next_addr = addr;
    next_prot = prot;
    next_reply_pend = reply_pend;
    next_reply_byte = reply_byte;
    next_reply_cnt = reply_cnt;
    push = '0;
    unique case (state)
      SPC_WAIT_SYNC: begin
        if (rx_valid && rx_data == SYNC_BYTE) begin
          next_out_byte = rx_data;
          next_cnt = dly(SYNC_ECHO_DELAY);
          next_after_state = SPC_WAIT_BAUD;
          next_state = SPC_DELAY;
        end
      end
      SPC_WAIT_BAUD: begin
        if (rx_valid && rx_data == BAUD_BYTE) begin
          next_out_byte = rx_data;
          next_cnt = dly(BAUD_ECHO_DELAY);
          next_after_state = SPC_IDLE_CMD;
          next_state = SPC_DELAY;
        end
      end
      SPC_IDLE_CMD: begin
        if (protect_req) begin
          next_cnt = dly(PROTECT_DELAY);
          next_prot = 1'b1;
          next_out_byte = BYTE_ONE;
          next_after_state = SPC_IDLE_CMD;
          next_state = SPC_DELAY;
        end else if (rx_valid) begin
          next_cmd = rx_data;
          next_out_byte = rx_data;
          next_cnt = dly(CMD_ECHO_DELAY);
          next_reply_cnt = op_delay(rx_data);
          next_after_state = SPC_IDLE_CMD;
          next_state = SPC_DELAY;
          // Echo always goes first; a reply byte, if any, follows it
          unique case (rx_data)
            OP_READ, OP_EMU, OP_ERASE: next_after_state = SPC_WAIT_ARG;
            OP_SUM: begin
              next_reply_byte = BYTE_ZERO;
              next_reply_pend = 1'b1;
            end
            OP_ID: begin
              next_reply_byte = PRODUCT_ID;
              next_reply_pend = 1'b1;
            end
            OP_STATUS: begin
              next_reply_byte = prot ? STATUS_PROT_BIT : STATUS_CLEAR;
              next_reply_pend = 1'b1;
            end
            default: next_reply_pend = 1'b0;
          endcase
        end
      end
      SPC_WAIT_ARG: begin
        if (rx_valid) begin
          next_state = SPC_DELAY;
          next_after_state = SPC_IDLE_CMD;
          next_out_byte = rx_data;
          unique case (cmd)
            OP_READ: begin
              next_remain = rx_data;
              next_addr = BYTE_ZERO;
              next_cnt = dly(READ_START_DELAY);
              next_after_state = SPC_READ_OUT;
            end
            OP_EMU: next_cnt = dly(EMU_ECHO_DELAY);
            OP_ERASE: begin
              next_cnt = dly(WRITE_RESP_DELAY);
              if (erase_password_free_option == ERASE_FREE_CODE
                  && rx_data != CHIP_ERASE_SEL) begin
                next_state = SPC_HALT;
              end else if (rx_data == CHIP_ERASE_SEL
                  && erase_password_free_option == ERASE_FREE_CODE) begin
                // No password path here, so erase only when password-free
                next_prot = 1'b0;
              end
            end
            default: next_cnt = dly(RAM_SUM_DELAY);
          endcase
        end
      end
      SPC_DELAY: begin
        // Received bytes dropped here
        if (cnt == '0) begin
          // Read data follows the delay directly, with no echo of the count
          next_state = (after_state == SPC_READ_OUT) ? SPC_READ_OUT : SPC_SEND;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      SPC_SEND: begin
        push.valid = 1'b1;
        push.data = out_byte;
        if (push_ready && reply_pend) begin
          // Reply byte waits its own delay after the echo
          next_reply_pend = 1'b0;
          next_out_byte = reply_byte;
          next_cnt = reply_cnt;
          next_state = SPC_DELAY;
        end else if (push_ready) begin
          next_state = after_state;
        end
      end
      SPC_READ_OUT: begin
        if (remain == '0) begin
          next_state = SPC_IDLE_CMD;
        end else begin
          push.valid = 1'b1;
          push.data = mem_rdata;
          if (push_ready) begin
            next_remain = remain - 1'b1;
            next_addr = addr + 1'b1;
          end
        end
      end
      SPC_HALT: next_state = SPC_HALT;
      default: next_state = SPC_WAIT_SYNC;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SPC_WAIT_SYNC;
      after_state <= SPC_WAIT_SYNC;
      cnt <= '0;
      cmd <= '0;
      out_byte <= '0;
      remain <= '0;
      addr <= '0;
      prot <= 1'b0;
      reply_pend <= 1'b0;
      reply_byte <= '0;
      reply_cnt <= '0;
      busy_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      state <= next_state;
      after_state <= next_after_state;
      cnt <= next_cnt;
      cmd <= next_cmd;
      out_byte <= next_out_byte;
      remain <= next_remain;
      addr <= next_addr;
      prot <= next_prot;
      reply_pend <= next_reply_pend;
      reply_byte <= next_reply_byte;
      reply_cnt <= next_reply_cnt;
      busy_q <= next_state == SPC_DELAY || next_state == SPC_SEND;
      halt_q <= next_state == SPC_HALT;
    end
  end

  // Transmit FIFO
  spc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push.valid),
    .in_ready(push_ready),
    .in_data(push.data),
    .out_valid(fifo_valid),
    .out_ready(!tx_valid),
    .out_data(fifo_data)
  );

  // Registered transmit stage; loads only when empty, so no byte leaves twice
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_valid <= 1'b0;
      tx_data <= '0;
    end else if (!tx_valid) begin
      tx_valid <= fifo_valid;
      tx_data <= fifo_data;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  // Status outputs from flops
  always_comb begin
    mem_addr = addr;
    busy = busy_q;
    halted = halt_q;
    protected_flag = prot;
  end
endmodule : spc_handler

// *** test/spc_handler_monitor.sv ***
// Port checker for the command handler.
// Assumes binding to the handler with one clock and active-low reset.
`timescale 1ns/10ps
module spc_handler_monitor
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Streams and status
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic [7:0] mem_addr,
  input wire logic busy,
  input wire logic halted
);
  logic [11:0] gap;
  logic [11:0] next_gap;
  logic [1:0] n_tx;
  logic [1:0] next_n_tx;
  // Cycles since a taken byte, accepted replies
  always_comb begin
    next_gap = (gap == 12'hFFF) ? gap : gap + 12'h001;
    if (rx_valid && !busy) next_gap = 12'h000;
    next_n_tx = (tx_valid && tx_ready && n_tx != 2'h3) ? n_tx + 2'h1 : n_tx;
  end
  // Helper registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      gap <= 12'h000;
      n_tx <= 2'h0;
    end else begin
      gap <= next_gap;
      n_tx <= next_n_tx;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("tx byte left early");
  property p_drop; tx_valid && tx_ready |=> !tx_valid; endproperty
  a_drop: assert property (p_drop) else $error("tx valid after accept");
  property p_halt; halted |=> halted; endproperty
  a_halt: assert property (p_halt) else $error("halt left");
  property p_mute; halted && !tx_valid |=> !tx_valid; endproperty
  a_mute: assert property (p_mute) else $error("reply while halted");
  property p_addr; busy |=> $stable(mem_addr); endproperty
  a_addr: assert property (p_addr) else $error("address moved while busy");
  property p_sync; $rose(tx_valid) && n_tx == 2'h0 |-> gap inside {[12'h28A:12'h2B2]}; endproperty
  a_sync: assert property (p_sync) else $error("sync echo delay");
  property p_baud; $rose(tx_valid) && n_tx == 2'h1 |-> gap inside {[12'h212:12'h23A]}; endproperty
  a_baud: assert property (p_baud) else $error("baud echo delay");
  property p_cmd; $rose(tx_valid) && n_tx == 2'h2 |-> gap inside {[12'h122:12'h14A]}; endproperty
  a_cmd: assert property (p_cmd) else $error("command echo delay");
  c_halt: cover property ($rose(halted));
  c_stall: cover property (tx_valid && !tx_ready);
  c_cmd: cover property ($rose(tx_valid) && n_tx == 2'h2);
endmodule : spc_handler_monitor

bind spc_handler spc_handler_monitor u_spc_handler_monitor (.ref_clk(ref_clk), .rst_b(rst_b),
  .rx_valid(rx_valid), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
  .mem_addr(mem_addr), .busy(busy), .halted(halted));

// *** test/spc_host_model.sv ***
// Host side model: drains the transmit stream.
// Assumes the handler's clock; slow stalls three cycles in four, hold stalls fully.
`timescale 1ns/10ps
module spc_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Transmit stream
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [7:0] tx_data,
  // Pacing and seen bytes
  input wire logic slow,
  input wire logic hold,
  output logic got_valid,
  output logic [7:0] got_data
);
  logic [1:0] pace;
  // Ready one cycle in four when slow
  assign tx_ready = !hold && (!slow || (pace == 2'h0));
  // Capture each accepted byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pace <= 2'h0;
      got_valid <= 1'b0;
      got_data <= 8'h00;
    end else begin
      pace <= pace + 2'h1;
      got_valid <= tx_valid && tx_ready;
      got_data <= tx_data;
    end
  end
endmodule : spc_host_model

// *** test/spc_handler_tb_top.sv ***
// Testbench for the command handler and its FIFO.
// Assumes a 10 MHz clock; checksum time shortened to 50 cycles.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s exp %0h got %0h", nm, e, g); end end
module spc_handler_tb_top
  import spc_pkg::*;
;
  logic ref_clk, rst_b, rx_valid, slow, protect_req, tx_valid, tx_ready;
  logic busy, halted, protected_flag, got_valid, hold;
  logic [7:0] rx_data, tx_data, mem_addr, opt, got_data;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  spc_handler #(.FLASH_SUM_CYCLES(50), .PRODUCT_ID(8'h3C)) u_spc_handler (.ref_clk(ref_clk),
    .rst_b(rst_b), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .erase_password_free_option(opt),
    .protect_req(protect_req), .mem_rdata(mem_addr ^ 8'hA5), .mem_addr(mem_addr),
    .busy(busy), .halted(halted), .protected_flag(protected_flag));
  spc_host_model u_spc_host_model (.ref_clk(ref_clk), .rst_b(rst_b), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .slow(slow), .hold(hold), .got_valid(got_valid),
    .got_data(got_data));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  // Hang limit
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task send(input logic [7:0] b);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
  endtask : send
  task gap(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : gap
  task expect_byte(input logic [7:0] e, input int lo, input int hi);
    int c;
    c = 0;
    do begin
      @(negedge ref_clk);
      c++;
    end while (got_valid !== 1'b1 && c < hi);
    `CHK("tx_byte", e, got_data)
    `CHK("delay", 1'b1, c >= lo && c < hi)
  endtask : expect_byte
  task op(input logic [7:0] b);
    send(b);
    expect_byte(b, 280, 360);
    gap(270);
  endtask : op
  ////////////////////////////////////////////////////////////////////////////////
  // FIFO fill and drain through a stalled 20-byte read
  task t_fill();
    op(OP_READ);
    hold <= 1'b1;
    send(8'h14);
    gap(500);
    `CHK("fifo_full", 8'h11, mem_addr)
    `CHK("stalled", 1'b1, tx_valid)
    hold <= 1'b0;
    for (int i = 0; i < 20; i++) expect_byte(8'(i) ^ 8'hA5, 0, 60);
    gap(20);
    `CHK("fifo_empty", 1'b0, tx_valid)
    gap(1100);
  endtask : t_fill
  task t_entry();
    send(SYNC_BYTE);
    expect_byte(SYNC_BYTE, 640, 720);
    gap(140);
    send(BAUD_BYTE);
    expect_byte(BAUD_BYTE, 520, 600);
    gap(90);
  endtask : t_entry
  task t_id();
    send(OP_ID);
    send(OP_STATUS);
    expect_byte(OP_ID, 278, 360);
    gap(270);
    expect_byte(8'h3C, 0, 400);
    gap(1100);
  endtask : t_id
  task t_protect();
    op(OP_STATUS);
    expect_byte(STATUS_CLEAR, 0, 400);
    gap(1100);
    @(posedge ref_clk);
    protect_req <= 1'b1;
    @(posedge ref_clk);
    protect_req <= 1'b0;
    expect_byte(BYTE_ONE, 1060, 1160);
    `CHK("protected", 1'b1, protected_flag)
    gap(1100);
    op(OP_STATUS);
    expect_byte(STATUS_PROT_BIT, 0, 400);
    gap(1100);
  endtask : t_protect
  task t_read();
    slow <= 1'b1;
    op(OP_READ);
    send(8'h05);
    expect_byte(8'hA5, 410, 520);
    for (int i = 1; i < 5; i++) expect_byte(8'(i) ^ 8'hA5, 0, 60);
    slow <= 1'b0;
    gap(1100);
  endtask : t_read
  task t_sum_emu();
    send(OP_SUM);
    expect_byte(OP_SUM, 280, 360);
    expect_byte(BYTE_ZERO, 40, 200);
    gap(1100);
    op(OP_EMU);
    send(8'h5C);
    expect_byte(8'h5C, 400, 480);
    gap(1100);
  endtask : t_sum_emu
  task t_erase();
    op(OP_ERASE);
    send(CHIP_ERASE_SEL);
    expect_byte(CHIP_ERASE_SEL, 180, 260);
    `CHK("kept", 1'b1, protected_flag)
    gap(1100);
    opt <= ERASE_FREE_CODE;
    op(OP_ERASE);
    send(CHIP_ERASE_SEL);
    expect_byte(CHIP_ERASE_SEL, 180, 260);
    `CHK("unprotected", 1'b0, protected_flag)
    gap(1100);
    op(OP_ERASE);
    send(8'h01);
    gap(400);
    `CHK("halted", 1'b1, halted)
    send(OP_ID);
    gap(400);
    `CHK("silent", 1'b0, tx_valid)
  endtask : t_erase
  // Main sequence
  initial begin
    rst_b = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    slow = 1'b0;
    protect_req = 1'b0;
    opt = 8'h00;
    hold = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    gap(20);
    t_entry();
    t_id();
    t_protect();
    t_read();
    t_fill();
    t_sum_emu();
    t_erase();
    results();
  end
endmodule : spc_handler_tb_top
